// ### bench/driver_zero_chk.sv
`timescale 1ns/1ps
`default_nettype none
module driver_zero_chk import driver_zero_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic true_pin_en,
    input wire logic comp_pin_en,
    input wire logic true_pin_inv,
    input wire logic comp_pin_inv,
    input wire logic diff_power_down,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input var swing_t diff_swing,
    input var driver_fmt_t driver_fmt
);
    // A write presented while reset is held never lands
    wire w = reg_wr && reg_addr == 10'h0f0 && !rst;
    logic [7:0] p;
    // Bus byte from the last edge, written or not, so each consequent reads as a decode of the write
    always_ff @(posedge clock) p <= reg_wdata;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    fmt_sel_a: assert property (w |=> driver_fmt == p[7]) else $error("format");
    pin_en_a: assert property (w |=> !p[7] || {comp_pin_en, true_pin_en} == p[6:5])
        else $error("pin enable");
    dif_pol_a: assert property (w |=> p[7] || {true_pin_inv, comp_pin_inv} == {p[3], !p[3]})
        else $error("diff polarity");
    cmos_pol_a: assert property (w |=> !p[7] ||
        {true_pin_inv, comp_pin_inv} == {p[3], ^p[4:3]}) else $error("cmos polarity");
    swing_sel_a: assert property (w |=> diff_swing == (p[2:1] == 2'h1 ? swing_other :
        swing_t'({&p[2:1], p[2:1] == 2'h2}))) else $error("swing");
    pdn_sel_a: assert property (w |=> diff_power_down == p[0]) else $error("power down");
    cfg_hold_a: assert property (!w |=> $stable({driver_fmt, true_pin_en, comp_pin_en,
        true_pin_inv, comp_pin_inv, diff_swing, diff_power_down})) else $error("hold");
    cover property (w);
    cover property (w && reg_wdata[7]);
    cover property (w ##1 w);
    cover property (reg_wr && !w);
endmodule // driver_zero_chk
bind driver_zero driver_zero_chk chk (.*);
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 0, rst = 1, reg_wr = 0;
    logic [9:0] reg_addr = 10'h0f0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, m = 8'h64;
    logic driver_fmt, true_pin_en, comp_pin_en, true_pin_inv, comp_pin_inv, diff_power_down;
    logic [1:0] diff_swing;
    int bad_count = 0, n_tests = 0;
    always #50 clock = ~clock;
    driver_zero dut (.clock, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
        .driver_fmt(driver_fmt), .true_pin_en, .comp_pin_en, .true_pin_inv, .comp_pin_inv,
        .diff_swing(diff_swing), .diff_power_down);
    // Pin controls that a control byte must produce
    function automatic logic [7:0] decode(input logic [7:0] v);
        logic [1:0] en;
        logic [1:0] inv;
        logic [1:0] sw;
        en = 2'h3;
        inv = {v[3], ~v[3]};
        if (v[7]) begin
            en = {v[5], v[6]};
            case (v[4:3])
                2'h0: inv = 2'h0;
                2'h1: inv = 2'h3;
                2'h2: inv = 2'h1;
                default: inv = 2'h2;
            endcase
        end
        case (v[2:1])
            2'h0: sw = 2'h0;
            2'h2: sw = 2'h1;
            2'h3: sw = 2'h2;
            default: sw = 2'h3;
        endcase
        return {v[7], en, inv, sw, v[0]};
    endfunction
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] s, e);
        n_tests++;
        bad_count += int'(s !== e);
        if (s !== e) $display("Error %s expected %h seen %h", what, e, s);
    endtask
    task automatic check_all(input logic [7:0] v, input logic mapped);
        logic [7:0] e;
        e = decode(v);
        chk("rdata", reg_rdata, mapped ? v : 8'h00);
        chk("format", 8'(driver_fmt), 8'(e[7]));
        chk("pin enable", 8'({true_pin_en, comp_pin_en}), 8'(e[6:5]));
        chk("polarity", 8'({true_pin_inv, comp_pin_inv}), 8'(e[4:3]));
        chk("swing", 8'(diff_swing), 8'(e[2:1]));
        chk("power down", 8'(diff_power_down), 8'(e[0]));
    endtask
    initial begin
        void'($urandom(32'h7c9a));
        repeat (20) @(posedge clock);
        // Second pass repeats the walk after a reset in mid-run
        for (int pass = 0; pass < 2; pass++) begin
            rst <= 0;
            reg_wr <= 1;
            reg_addr <= 10'h0f0;
            m = 8'h64;
            #1 check_all(m, 1'b1);
            // Stray addresses and idle strobes must leave the register alone
            for (int i = 0; i < 200; i++) begin
                @(posedge clock);
                if (reg_wr && reg_addr == 10'h0f0) m = reg_wdata;
                // First writes walk every CMOS pin and polarity code
                reg_wr <= i < 16 || $urandom % 4 != 0;
                reg_addr <= i < 16 || $urandom % 4 != 0 ? 10'h0f0 : 10'($urandom);
                reg_wdata <= i < 16 ? {1'b1, 4'(i), 3'h2} : 8'($urandom);
                #1 check_all(m, reg_addr == 10'h0f0);
            end
            @(posedge clock);
            rst <= 1;
            @(posedge clock);
        end
        conclude;
    end
endmodule // testbench
`default_nettype wire

// ### design/driver_zero.sv
// Contract
// - CMOS bits 6:5 enable true/comp pins
// - Differential: bit 3 swaps pin polarities
// - CMOS: bits 4:3 decode per-pin inversion
// - Bits 2:1 select differential swing level
// - Bit 0 powers down differential driver
`include "driver_zero_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module driver_zero
    import driver_zero_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output driver_fmt_t driver_fmt,
    output logic true_pin_en,
    output logic comp_pin_en,
    output logic true_pin_inv,
    output logic comp_pin_inv,
    output swing_t diff_swing,
    output logic diff_power_down
);
    localparam logic [7:0] CTRL_RESET = `FIRST_DRIVER_CONTROL_RESET;

    // Stored fields of the control byte
    logic fmt_r;
    logic [1:0] pin_cfg_r;
    logic [1:0] pol_r;
    logic [1:0] swing_code_r;
    logic pdn_r;
    logic fmt_nxt;
    logic [1:0] pin_cfg_nxt;
    logic [1:0] pol_nxt;
    logic [1:0] swing_code_nxt;
    logic pdn_nxt;
    logic [7:0] ctrl_word;
    logic wr_hit;

    // Pin controls leave flops, never raw decode, so the stage sees no glitches
    driver_fmt_t driver_fmt_r;
    logic true_pin_en_r;
    logic comp_pin_en_r;
    logic true_pin_inv_r;
    logic comp_pin_inv_r;
    swing_t diff_swing_r;
    logic diff_power_down_r;
    driver_fmt_t driver_fmt_nxt;
    logic true_pin_en_nxt;
    logic comp_pin_en_nxt;
    logic true_pin_inv_nxt;
    logic comp_pin_inv_nxt;
    swing_t diff_swing_nxt;
    logic diff_power_down_nxt;

    assign wr_hit = reg_wr && (reg_addr == `FIRST_DRIVER_CONTROL_ADDR);

    // A write lands in every field on the same edge
    always_comb begin
        fmt_nxt = fmt_r;
        pin_cfg_nxt = pin_cfg_r;
        pol_nxt = pol_r;
        swing_code_nxt = swing_code_r;
        pdn_nxt = pdn_r;
        if (wr_hit) begin
            fmt_nxt = reg_wdata[`FMT_BIT];
            pin_cfg_nxt = reg_wdata[`CMOS_CFG_HI:`CMOS_CFG_LO];
            pol_nxt = reg_wdata[`POL_HI:`POL_LO];
            swing_code_nxt = reg_wdata[`SWING_HI:`SWING_LO];
            pdn_nxt = reg_wdata[`PDN_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fmt_r <= CTRL_RESET[`FMT_BIT];
        end else begin
            fmt_r <= fmt_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_cfg_r <= CTRL_RESET[`CMOS_CFG_HI:`CMOS_CFG_LO];
        end else begin
            pin_cfg_r <= pin_cfg_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pol_r <= CTRL_RESET[`POL_HI:`POL_LO];
        end else begin
            pol_r <= pol_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            swing_code_r <= CTRL_RESET[`SWING_HI:`SWING_LO];
        end else begin
            swing_code_r <= swing_code_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pdn_r <= CTRL_RESET[`PDN_BIT];
        end else begin
            pdn_r <= pdn_nxt;
        end
    end

    // Readback rebuilds the byte from its fields
    assign ctrl_word = {fmt_r, pin_cfg_r, pol_r, swing_code_r, pdn_r};

    // Unmapped addresses read as zero
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_addr == `FIRST_DRIVER_CONTROL_ADDR) begin
            reg_rdata = ctrl_word;
        end
    end

    // Decoding the next value keeps the pins in step with the readback
    always_comb begin
        driver_fmt_nxt = fmt_nxt ? fmt_cmos : fmt_diff;
        true_pin_en_nxt = 1'b1;
        comp_pin_en_nxt = 1'b1;
        // Bit 4 has no effect in this mode
        true_pin_inv_nxt = pol_nxt[0];
        comp_pin_inv_nxt = ~pol_nxt[0];
        if (fmt_nxt) begin
            // Code 00 leaves both pins off
            true_pin_en_nxt = (pin_cfg_nxt == `CMOS_TRUE_ONLY)
                || (pin_cfg_nxt == `CMOS_BOTH);
            comp_pin_en_nxt = (pin_cfg_nxt == `CMOS_COMP_ONLY)
                || (pin_cfg_nxt == `CMOS_BOTH);
            unique case (pol_nxt)
                `POL_NONE: begin
                    true_pin_inv_nxt = 1'b0;
                    comp_pin_inv_nxt = 1'b0;
                end
                `POL_BOTH: begin
                    true_pin_inv_nxt = 1'b1;
                    comp_pin_inv_nxt = 1'b1;
                end
                `POL_COMP: begin
                    true_pin_inv_nxt = 1'b0;
                    comp_pin_inv_nxt = 1'b1;
                end
                `POL_TRUE: begin
                    true_pin_inv_nxt = 1'b1;
                    comp_pin_inv_nxt = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        unique case (swing_code_nxt)
            `SWING_400: diff_swing_nxt = swing_400mv;
            `SWING_780: diff_swing_nxt = swing_780mv;
            `SWING_960: diff_swing_nxt = swing_960mv;
            default: diff_swing_nxt = swing_other;
        endcase
    end

    assign diff_power_down_nxt = pdn_nxt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            driver_fmt_r <= driver_fmt_t'(CTRL_RESET[`FMT_BIT]);
        end else begin
            driver_fmt_r <= driver_fmt_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            true_pin_en_r <= `TRUE_EN_RESET;
        end else begin
            true_pin_en_r <= true_pin_en_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            comp_pin_en_r <= `COMP_EN_RESET;
        end else begin
            comp_pin_en_r <= comp_pin_en_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            true_pin_inv_r <= `TRUE_INV_RESET;
        end else begin
            true_pin_inv_r <= true_pin_inv_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            comp_pin_inv_r <= `COMP_INV_RESET;
        end else begin
            comp_pin_inv_r <= comp_pin_inv_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            diff_swing_r <= swing_780mv;
        end else begin
            diff_swing_r <= diff_swing_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            diff_power_down_r <= CTRL_RESET[`PDN_BIT];
        end else begin
            diff_power_down_r <= diff_power_down_nxt;
        end
    end

    // Ports show the flops directly
    assign driver_fmt = driver_fmt_r;
    assign true_pin_en = true_pin_en_r;
    assign comp_pin_en = comp_pin_en_r;
    assign true_pin_inv = true_pin_inv_r;
    assign comp_pin_inv = comp_pin_inv_r;
    assign diff_swing = diff_swing_r;
    assign diff_power_down = diff_power_down_r;
endmodule // driver_zero
`default_nettype wire

// ### design/driver_zero_cfg.svh
`ifndef DRIVER_ZERO_CFG_SVH
`define DRIVER_ZERO_CFG_SVH
`define FIRST_DRIVER_CONTROL_ADDR 10'h0f0
`define FIRST_DRIVER_CONTROL_RESET 8'h64
`define TRUE_EN_RESET 1'b1
`define COMP_EN_RESET 1'b1
`define TRUE_INV_RESET 1'b0
`define COMP_INV_RESET 1'b1
`define FMT_BIT 7
`define CMOS_CFG_HI 6
`define CMOS_CFG_LO 5
`define POL_HI 4
`define POL_LO 3
`define SWING_HI 2
`define SWING_LO 1
`define PDN_BIT 0
`define CMOS_TRUE_ONLY 2'h1
`define CMOS_COMP_ONLY 2'h2
`define CMOS_BOTH 2'h3
`define POL_NONE 2'h0
`define POL_BOTH 2'h1
`define POL_COMP 2'h2
`define POL_TRUE 2'h3
`define SWING_400 2'h0
`define SWING_780 2'h2
`define SWING_960 2'h3
`endif

// ### design/driver_zero_pkg.sv
`default_nettype none
package driver_zero_pkg;
    typedef enum logic {fmt_diff, fmt_cmos} driver_fmt_t;
    typedef enum logic [1:0] {swing_400mv, swing_780mv, swing_960mv, swing_other} swing_t;
endpackage
`default_nettype wire
